// ---- hdl/eth_dma_diag_status_regs.sv ----
// Missed-frame counters, receive watchdog and DMA status registers.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "eth_dma_diag_cfg.svh"

// Behaviour
// - An 11-bit internal-drop count reads in bits 27:17, zeroed on read.
// - That count advances on overflow drops and on dropped runt frames.
// - Bit 28 flags that the internal-drop count has wrapped.
// - A 16-bit no-buffer missed count reads in bits 15:0, zeroed on read.
// - Bit 16 flags that the no-buffer count has wrapped.
// - The watchdog runs only while its 8-bit count is non-zero.
// - The timeout is the programmed count times 256 clock cycles.
// - The watchdog starts when a frame with a suppressed interrupt ends.
// - On expiry the receive interrupt flag is set and the watchdog halts.
// - A frame that sets the receive interrupt flag resets the watchdog.
// - Read-only bit 0 reads 1 while the bus master interface is busy.
// - A read-only 32-bit register holds the current tx descriptor address.
// - That pointer clears on reset and ignores software writes.
module eth_dma_diag_status_regs (
    input  wire logic                          ref_clk_i,
    input  wire logic                          rst_i,
    input  wire logic [`ADDR_W-1:0]            reg_addr_i,
    input  wire logic [31:0]                   reg_wdata_i,
    input  wire logic                          reg_wr_i,
    input  wire logic                          reg_rd_i,
    output logic [31:0]                        reg_rdata_o,
    input  wire eth_dma_diag_pkg::rx_event_s   rx_event_i,
    input  wire logic                          master_bus_active_i,
    input  wire logic                          tx_desc_load_i,
    input  wire logic [31:0]                   tx_desc_addr_i,
    output logic                               receive_interrupt_set_o,
    output logic                               irq_o
);

    logic [31:0]             rdata_ff;
    logic [31:0]             nxt_rdata;
    logic [`WDG_COUNT_W-1:0] rx_watchdog_count_ff;
    logic [`WDG_COUNT_W-1:0] nxt_rx_watchdog_count;
    logic [31:0]             tx_descriptor_pointer_ff;
    logic [31:0]             nxt_tx_descriptor_pointer;
    logic                    master_bus_active_ff;
    logic                    nxt_master_bus_active;
    logic                    rx_irq_set_ff;
    logic                    nxt_rx_irq_set;
    logic [`IRQ_W-1:0]       irq_status_ff;
    logic [`IRQ_W-1:0]       nxt_irq_status;
    logic [`IRQ_W-1:0]       irq_enable_ff;
    logic [`IRQ_W-1:0]       nxt_irq_enable;

    logic                      missed_read;
    logic [`NB_CNT_W-1:0]      no_buffer_drop_count;
    logic                      no_buffer_drop_count_wrapped;
    logic                      nb_wrap_pulse;
    logic [`ID_CNT_W-1:0]      internal_drop_count;
    logic                      internal_drop_count_wrapped;
    logic                      id_wrap_pulse;
    logic                      wdg_expire;
    logic                      wdg_start;
    logic                      wdg_restart;
    logic                      desc_irq_frame;
    logic [`IRQ_W-1:0]         irq_events;

    function automatic logic hit(input logic [`ADDR_W-1:0] a,
                                 input logic [`ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    assign missed_read = reg_rd_i && hit(reg_addr_i, `OFF_MISSED_FRAMES);

    drop_counter #(
        .W (`NB_CNT_W)
    ) u_no_buffer_cnt (
        .ref_clk_i    (ref_clk_i),
        .rst_i        (rst_i),
        .inc_i        ({1'b0, rx_event_i.no_buffer_drop}),
        .clear_i      (missed_read),
        .count_o      (no_buffer_drop_count),
        .wrapped_o    (no_buffer_drop_count_wrapped),
        .wrap_pulse_o (nb_wrap_pulse)
    );

    drop_counter #(
        .W (`ID_CNT_W)
    ) u_internal_cnt (
        .ref_clk_i    (ref_clk_i),
        .rst_i        (rst_i),
        .inc_i        ({rx_event_i.overflow_drop,
                        rx_event_i.runt_drop}),
        .clear_i      (missed_read),
        .count_o      (internal_drop_count),
        .wrapped_o    (internal_drop_count_wrapped),
        .wrap_pulse_o (id_wrap_pulse)
    );

    // A frame that completes with its interrupt suppressed arms the timer.
    assign wdg_start      = rx_event_i.rx_done
                            && rx_event_i.irq_suppress;
    assign desc_irq_frame = rx_event_i.rx_done && !rx_event_i.irq_suppress;
    assign wdg_restart    = desc_irq_frame;

    rx_watchdog #(
        .CW (`WDG_COUNT_W)
    ) u_watchdog (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .count_i   (rx_watchdog_count_ff),
        .start_i   (wdg_start),
        .restart_i (wdg_restart),
        .expire_o  (wdg_expire),
        .running_o ()
    );

    assign irq_events = {desc_irq_frame | wdg_expire, id_wrap_pulse,
                         nb_wrap_pulse, wdg_expire};

    always_comb begin
        nxt_rx_watchdog_count     = rx_watchdog_count_ff;
        nxt_tx_descriptor_pointer = tx_descriptor_pointer_ff;
        nxt_master_bus_active     = master_bus_active_i;
        nxt_rx_irq_set            = desc_irq_frame | wdg_expire;
        nxt_irq_enable            = irq_enable_ff;
        nxt_irq_status            = irq_status_ff;
        if (reg_wr_i && hit(reg_addr_i, `OFF_RX_WATCHDOG)) begin
            nxt_rx_watchdog_count = reg_wdata_i[`WDG_COUNT_W-1:0];
        end
        if (reg_wr_i && hit(reg_addr_i, `OFF_IRQ_ENABLE)) begin
            nxt_irq_enable = reg_wdata_i[`IRQ_W-1:0];
        end
        if (reg_wr_i && hit(reg_addr_i, `OFF_IRQ_CLEAR)) begin
            nxt_irq_status = irq_status_ff & ~reg_wdata_i[`IRQ_W-1:0];
        end
        // Set after clear so a same-cycle event survives the clear.
        nxt_irq_status = nxt_irq_status | irq_events;
        // Only the DMA moves the pointer; register writes never reach it.
        if (tx_desc_load_i) begin
            nxt_tx_descriptor_pointer = tx_desc_addr_i;
        end
    end

    always_comb begin
        nxt_rdata = '0;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `OFF_MISSED_FRAMES: begin
                    nxt_rdata[`NB_CNT_LSB +: `NB_CNT_W] =
                        no_buffer_drop_count;
                    nxt_rdata[`NB_WRAP_BIT] =
                        no_buffer_drop_count_wrapped;
                    nxt_rdata[`ID_CNT_LSB +: `ID_CNT_W] =
                        internal_drop_count;
                    nxt_rdata[`ID_WRAP_BIT] =
                        internal_drop_count_wrapped;
                end
                `OFF_RX_WATCHDOG: begin
                    nxt_rdata[`WDG_COUNT_W-1:0] = rx_watchdog_count_ff;
                end
                `OFF_BUS_MASTER_STATUS: begin
                    nxt_rdata[`BUS_ACTIVE_BIT] = master_bus_active_ff;
                end
                `OFF_CUR_TX_DESC: begin
                    nxt_rdata = tx_descriptor_pointer_ff;
                end
                `OFF_IRQ_STATUS: begin
                    nxt_rdata[`IRQ_W-1:0] = irq_status_ff;
                end
                `OFF_IRQ_ENABLE: begin
                    nxt_rdata[`IRQ_W-1:0] = irq_enable_ff;
                end
                default: begin
                    nxt_rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_ff                 <= '0;
            rx_watchdog_count_ff     <= '0;
            tx_descriptor_pointer_ff <= '0;
            master_bus_active_ff     <= 1'b0;
            rx_irq_set_ff            <= 1'b0;
            irq_status_ff            <= '0;
            irq_enable_ff            <= '0;
        end else begin
            rdata_ff                 <= nxt_rdata;
            rx_watchdog_count_ff     <= nxt_rx_watchdog_count;
            tx_descriptor_pointer_ff <= nxt_tx_descriptor_pointer;
            master_bus_active_ff     <= nxt_master_bus_active;
            rx_irq_set_ff            <= nxt_rx_irq_set;
            irq_status_ff            <= nxt_irq_status;
            irq_enable_ff            <= nxt_irq_enable;
        end
    end

    assign reg_rdata_o             = rdata_ff;
    assign receive_interrupt_set_o = rx_irq_set_ff;
    assign irq_o                   = |(irq_status_ff & irq_enable_ff);

endmodule : eth_dma_diag_status_regs

// ---- hdl/eth_dma_diag_cfg.svh ----
// Offsets, field positions and timing counts for the diagnostic registers.
`ifndef ETH_DMA_DIAG_CFG_SVH
`define ETH_DMA_DIAG_CFG_SVH

`define ADDR_W                 16
`define OFF_MISSED_FRAMES      16'h1020
`define OFF_RX_WATCHDOG        16'h1024
`define OFF_BUS_MASTER_STATUS  16'h102c
`define OFF_CUR_TX_DESC        16'h1048
`define OFF_IRQ_STATUS         16'h1080
`define OFF_IRQ_ENABLE         16'h1084
`define OFF_IRQ_CLEAR          16'h1088

`define NB_CNT_LSB             0
`define NB_CNT_W               16
`define NB_WRAP_BIT            16
`define ID_CNT_LSB             17
`define ID_CNT_W               11
`define ID_WRAP_BIT            28
`define BUS_ACTIVE_BIT         0

`define WDG_COUNT_W            8
`define WDG_UNIT_CYCLES        256
`define WDG_PRESCALE_W         8

`define IRQ_W                  4
`define IRQ_WDG_EXPIRED        0
`define IRQ_NB_WRAP            1
`define IRQ_ID_WRAP            2
`define IRQ_RX_DONE            3

`endif

// ---- hdl/eth_dma_diag_pkg.sv ----
// Types shared by the diagnostic register block and its submodules.
package eth_dma_diag_pkg;

    typedef struct packed {
        logic        rx_done;
        logic        irq_suppress;
        logic        overflow_drop;
        logic        runt_drop;
        logic        no_buffer_drop;
    } rx_event_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

    typedef enum logic [1:0] {
        WDG_IDLE,
        WDG_RUN,
        WDG_HALT
    } wdg_state_e;

endpackage : eth_dma_diag_pkg

// ---- hdl/drop_counter.sv ----
// Saturation-free event counter with sticky wrap flag and clear-on-read.
`timescale 1ns/1ps
`include "eth_dma_diag_cfg.svh"

module drop_counter #(
    parameter int W = 16
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire logic [1:0]   inc_i,
    input  wire logic         clear_i,
    output logic [W-1:0]      count_o,
    output logic              wrapped_o,
    output logic              wrap_pulse_o
);

    logic [W-1:0] count_ff;
    logic [W-1:0] nxt_count;
    logic         wrapped_ff;
    logic         nxt_wrapped;
    logic [W:0]   sum;

    // Events in the read cycle start the new count, so none is lost.
    always_comb begin
        sum = {1'b0, (clear_i ? {W{1'b0}} : count_ff)} + (W+1)'(inc_i[0])
              + (W+1)'(inc_i[1]);
        nxt_count    = sum[W-1:0];
        wrap_pulse_o = sum[W];
        nxt_wrapped  = (clear_i ? 1'b0 : wrapped_ff) | sum[W];
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_ff   <= '0;
            wrapped_ff <= 1'b0;
        end else begin
            count_ff   <= nxt_count;
            wrapped_ff <= nxt_wrapped;
        end
    end

    assign count_o   = count_ff;
    assign wrapped_o = wrapped_ff;

endmodule : drop_counter

// ---- hdl/rx_watchdog.sv ----
// Receive interrupt watchdog: prescaler, countdown and expiry pulse.
`timescale 1ns/1ps
`include "eth_dma_diag_cfg.svh"

module rx_watchdog #(
    parameter int CW = `WDG_COUNT_W
) (
    input  wire logic          ref_clk_i,
    input  wire logic          rst_i,
    input  wire logic [CW-1:0] count_i,
    input  wire logic          start_i,
    input  wire logic          restart_i,
    output logic               expire_o,
    output logic               running_o
);

    localparam int PW = `WDG_PRESCALE_W;
    localparam logic [PW-1:0] PRE_LAST = PW'(`WDG_UNIT_CYCLES - 1);

    eth_dma_diag_pkg::wdg_state_e state_ff;
    eth_dma_diag_pkg::wdg_state_e nxt_state;
    logic [PW-1:0] pre_ff;
    logic [PW-1:0] nxt_pre;
    logic [CW-1:0] units_ff;
    logic [CW-1:0] nxt_units;
    logic          tick;

    always_comb begin
        nxt_state = state_ff;
        nxt_pre   = pre_ff;
        nxt_units = units_ff;
        expire_o  = 1'b0;
        tick      = (pre_ff == PRE_LAST);
        unique case (state_ff)
            eth_dma_diag_pkg::WDG_IDLE,
            eth_dma_diag_pkg::WDG_HALT: begin
                nxt_pre = '0;
            end
            eth_dma_diag_pkg::WDG_RUN: begin
                nxt_pre = tick ? '0 : pre_ff + PW'(1);
                if (tick) begin
                    nxt_units = units_ff - CW'(1);
                    if (units_ff == CW'(1)) begin
                        expire_o  = 1'b1;
                        nxt_state = eth_dma_diag_pkg::WDG_HALT;
                    end
                end
            end
        endcase
        // Timeout is count times 256 cycles from the start event.
        if (start_i && count_i != '0) begin
            nxt_state = eth_dma_diag_pkg::WDG_RUN;
            nxt_pre   = '0;
            nxt_units = count_i;
            expire_o  = 1'b0;
        end
        if (restart_i || count_i == '0) begin
            nxt_state = eth_dma_diag_pkg::WDG_IDLE;
            nxt_pre   = '0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= eth_dma_diag_pkg::WDG_IDLE;
            pre_ff   <= '0;
            units_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            pre_ff   <= nxt_pre;
            units_ff <= nxt_units;
        end
    end

    assign running_o = (state_ff == eth_dma_diag_pkg::WDG_RUN);

endmodule : rx_watchdog

// ---- testbench/eth_dma_diag_status_regs_asserts.sv ----
// Concurrent checks on the ports of the diagnostic register block.
`timescale 1ns/1ps
`include "eth_dma_diag_cfg.svh"
module eth_dma_diag_status_regs_asserts (
    input wire logic                        ref_clk_i,
    input wire logic                        rst_i,
    input wire logic [`ADDR_W-1:0]          reg_addr_i,
    input wire logic [31:0]                 reg_wdata_i,
    input wire logic                        reg_wr_i,
    input wire logic                        reg_rd_i,
    input wire logic [31:0]                 reg_rdata_o,
    input wire eth_dma_diag_pkg::rx_event_s rx_event_i,
    input wire logic                        master_bus_active_i,
    input wire logic                        tx_desc_load_i,
    input wire logic [31:0]                 tx_desc_addr_i,
    input wire logic                        receive_interrupt_set_o,
    input wire logic                        irq_o
);
    logic [31:0] ptr_ff;
    logic [7:0]  wdg_ff;
    logic [9:0]  since_ff;
    logic        live_ff;
    logic        start;
    logic        rx_irq;
    logic        quiet;
    logic        wdg_wr;
    assign start  = rx_event_i.rx_done && rx_event_i.irq_suppress;
    assign rx_irq = rx_event_i.rx_done && !rx_event_i.irq_suppress;
    assign quiet  = !(rx_event_i.overflow_drop || rx_event_i.runt_drop ||
                      rx_event_i.no_buffer_drop);
    assign wdg_wr = reg_wr_i && reg_addr_i == `OFF_RX_WATCHDOG;
    // A timing run ends on a restart, a rewrite or its own expiry pulse.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ptr_ff <= 32'h0;
            wdg_ff <= 8'h0;
            since_ff <= 10'h0;
            live_ff <= 1'b0;
        end else begin
            if (tx_desc_load_i) ptr_ff <= tx_desc_addr_i;
            if (wdg_wr) wdg_ff <= reg_wdata_i[7:0];
            since_ff <= start ? 10'h0 : since_ff + 10'h1;
            if (start) live_ff <= 1'b1;
            else if (rx_irq || wdg_wr || receive_interrupt_set_o)
                live_ff <= 1'b0;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    a_status_bit: assert property (
        reg_rd_i && reg_addr_i == `OFF_BUS_MASTER_STATUS |=>
        reg_rdata_o == {31'h0, $past(master_bus_active_i, 2)})
        else $error("bus status bit wrong");
    a_pointer_read: assert property (
        reg_rd_i && reg_addr_i == `OFF_CUR_TX_DESC |=>
        reg_rdata_o == $past(ptr_ff)) else $error("pointer read wrong");
    a_wdg_read: assert property (
        reg_rd_i && reg_addr_i == `OFF_RX_WATCHDOG |=>
        reg_rdata_o == {24'h0, $past(wdg_ff)}) else $error("count wrong");
    a_wdg_early: assert property (
        live_ff && wdg_ff == 8'h01 && since_ff < 10'd254 |->
        !receive_interrupt_set_o) else $error("watchdog fired early");
    a_wdg_late: assert property (
        live_ff && wdg_ff == 8'h01 |-> since_ff < 10'd259)
        else $error("watchdog fired late");
    a_frame_irq: assert property (
        rx_irq |=> receive_interrupt_set_o) else $error("no frame pulse");
    a_no_spurious: assert property (
        receive_interrupt_set_o |-> $past(rx_irq) || wdg_ff != 8'h0)
        else $error("pulse without cause");
    a_read_clears: assert property (
        reg_rd_i && reg_addr_i == `OFF_MISSED_FRAMES && quiet ##1
        reg_rd_i && reg_addr_i == `OFF_MISSED_FRAMES && quiet |=>
        reg_rdata_o == 32'h0) else $error("counters not cleared");
    c_expire: cover property (start ##[256:258] receive_interrupt_set_o);
    c_count: cover property (reg_rd_i ##1 reg_rdata_o[28]);
    c_irq: cover property (irq_o);
endmodule : eth_dma_diag_status_regs_asserts

bind eth_dma_diag_status_regs eth_dma_diag_status_regs_asserts chk (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .rx_event_i(rx_event_i),
    .master_bus_active_i(master_bus_active_i),
    .tx_desc_load_i(tx_desc_load_i), .tx_desc_addr_i(tx_desc_addr_i),
    .receive_interrupt_set_o(receive_interrupt_set_o), .irq_o(irq_o));

// ---- testbench/dma_side_model.sv ----
// Stand-in for the DMA engine that raises frame events and pointer loads.
`timescale 1ns/1ps
module dma_side_model (
    input  wire logic                   ref_clk_i,
    output eth_dma_diag_pkg::rx_event_s rx_event_o,
    output logic                        master_bus_active_o,
    output logic                        tx_desc_load_o,
    output logic [31:0]                 tx_desc_addr_o
);
    initial begin
        rx_event_o = '0;
        master_bus_active_o = 1'b0;
        tx_desc_load_o = 1'b0;
        tx_desc_addr_o = 32'h0;
    end
    // Holds one event pattern for n edges in a row, then drops it.
    task automatic burst(input eth_dma_diag_pkg::rx_event_s ev,
                         input int n);
        @(posedge ref_clk_i);
        rx_event_o <= ev;
        repeat (n) @(posedge ref_clk_i);
        rx_event_o <= '0;
    endtask : burst
    // The address bus goes stale after a load, so a pointer that kept
    // following it would show the inverted value.
    task automatic load_ptr(input logic [31:0] a);
        @(posedge ref_clk_i);
        tx_desc_load_o <= 1'b1;
        tx_desc_addr_o <= a;
        @(posedge ref_clk_i);
        tx_desc_load_o <= 1'b0;
        tx_desc_addr_o <= ~a;
    endtask : load_ptr
    task automatic set_active(input logic act);
        @(posedge ref_clk_i);
        master_bus_active_o <= act;
    endtask : set_active
endmodule : dma_side_model

// ---- testbench/eth_dma_diag_status_regs_bench.sv ----
// Self-checking bench for the diagnostic register block.
`timescale 1ns/1ps
`include "eth_dma_diag_cfg.svh"
module eth_dma_diag_status_regs_bench;
    localparam logic [4:0] EV_NB = 5'h01;
    localparam logic [4:0] EV_RUNT = 5'h02;
    localparam logic [4:0] EV_OVF = 5'h04;
    localparam logic [4:0] EV_START = 5'h18;
    localparam logic [4:0] EV_FRAME = 5'h10;
    logic                        clk;
    logic                        rst;
    logic [`ADDR_W-1:0]          addr;
    logic [31:0]                 wdata;
    logic                        wr;
    logic                        rd;
    logic [31:0]                 rdata;
    eth_dma_diag_pkg::rx_event_s ev;
    logic                        act;
    logic                        load;
    logic [31:0]                 ptr;
    logic                        rx_irq_pulse;
    logic                        irq;
    int                          failures;
    int                          tests_run;
    always #5 clk = ~clk;
    dma_side_model mdl (.ref_clk_i(clk), .rx_event_o(ev),
        .master_bus_active_o(act), .tx_desc_load_o(load),
        .tx_desc_addr_o(ptr));
    eth_dma_diag_status_regs dut (.ref_clk_i(clk), .rst_i(rst),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .rx_event_i(ev),
        .master_bus_active_i(act), .tx_desc_load_i(load),
        .tx_desc_addr_i(ptr), .receive_interrupt_set_o(rx_irq_pulse),
        .irq_o(irq));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    task automatic wait_set(input int lim, output int n);
        n = 0;
        while (rx_irq_pulse !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_set
    task automatic t_reset();
        logic [15:0] offs [6] = '{`OFF_MISSED_FRAMES, `OFF_RX_WATCHDOG,
            `OFF_BUS_MASTER_STATUS, `OFF_CUR_TX_DESC, `OFF_IRQ_CLEAR,
            16'h1030};
        logic [31:0] d;
        foreach (offs[i]) begin
            rd_reg(offs[i], d);
            check(d, 32'h0);
        end
    endtask : t_reset
    task automatic t_pointer_status();
        logic [31:0] d;
        mdl.load_ptr(32'h8000_1230);
        wr_reg(`OFF_CUR_TX_DESC, 32'hffff_ffff);
        rd_reg(`OFF_CUR_TX_DESC, d);
        check(d, 32'h8000_1230);
        mdl.set_active(1'b1);
        wr_reg(`OFF_BUS_MASTER_STATUS, 32'h0);
        rd_reg(`OFF_BUS_MASTER_STATUS, d);
        check(d, 32'h1);
        mdl.set_active(1'b0);
        rd_reg(`OFF_BUS_MASTER_STATUS, d);
        check(d, 32'h0);
    endtask : t_pointer_status
    task automatic t_counters();
        logic [31:0] d;
        mdl.burst(EV_NB, 3);
        mdl.burst(EV_OVF, 1);
        mdl.burst(EV_RUNT, 1);
        mdl.burst(EV_OVF | EV_RUNT, 1);
        rd_reg(`OFF_MISSED_FRAMES, d);
        check(d, {4'h0, 11'd4, 1'b0, 16'd3});
        rd_reg(`OFF_MISSED_FRAMES, d);
        check(d, 32'h0);
    endtask : t_counters
    task automatic t_watchdog();
        logic [31:0] d;
        int n;
        wr_reg(`OFF_IRQ_ENABLE, 32'h1);
        wr_reg(`OFF_RX_WATCHDOG, 32'h101);
        rd_reg(`OFF_RX_WATCHDOG, d);
        check(d, 32'h1);
        mdl.burst(EV_START, 1);
        wait_set(300, n);
        check({31'h0, n > 253 && n < 259}, 32'h1);
        @(posedge clk);
        #1;
        check({31'h0, irq}, 32'h1);
        rd_reg(`OFF_IRQ_STATUS, d);
        check(d, 32'h9);
        wr_reg(`OFF_IRQ_CLEAR, 32'h1);
        #1;
        check({31'h0, irq}, 32'h0);
        mdl.burst(EV_START, 1);
        repeat (100) @(posedge clk);
        mdl.burst(EV_FRAME, 1);
        // The flag pulse stands for one cycle only, so look at it now.
        #1;
        check({31'h0, rx_irq_pulse}, 32'h1);
        @(posedge clk);
        #1;
        wait_set(400, n);
        check(n, 32'd400);
        wr_reg(`OFF_RX_WATCHDOG, 32'h0);
        mdl.burst(EV_START, 1);
        wait_set(400, n);
        check(n, 32'd400);
    endtask : t_watchdog
    task automatic t_wrap();
        wr_reg(`OFF_IRQ_ENABLE, 32'h6);
        mdl.burst(EV_NB | EV_OVF | EV_RUNT, 1025);
        mdl.burst(EV_NB, 65536);
        @(posedge clk);
        addr <= `OFF_MISSED_FRAMES;
        rd <= 1'b1;
        #1;
        check({31'h0, irq}, 32'h1);
        @(posedge clk);
        #1;
        check(rdata, {3'h0, 1'b1, 11'd2, 1'b1, 16'd1025});
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, 32'h0);
        wr_reg(`OFF_IRQ_CLEAR, 32'h6);
        #1;
        check({31'h0, irq}, 32'h0);
    endtask : t_wrap
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        addr = '0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        failures = 0;
        tests_run = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_pointer_status();
        t_counters();
        t_watchdog();
        t_wrap();
        finish_test();
    end
    // The longest scenario runs some 67000 cycles; a hang is cut at 100000.
    initial begin
        #1000000;
        failures++;
        finish_test();
    end
endmodule : eth_dma_diag_status_regs_bench
